// ===== hw/oac_config_regs.sv
// amplifier configuration register bank with an APB slave port
// assumes an APB master on core_clk; the analog side samples the decoded controls
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module oac_config_regs (
  // clock and reset
  input  wire logic                                  core_clk,
  input  wire logic                                  reset_n,
  // apb slave
  input  wire logic                                  psel,
  input  wire logic                                  penable,
  input  wire logic                                  pwrite,
  input  wire logic [oac_pkg::ADDR_W-1:0]            paddr,
  input  wire logic [oac_pkg::DATA_W-1:0]            pwdata,
  input  wire logic [3:0]                            pstrb,
  output logic      [oac_pkg::DATA_W-1:0]            prdata,
  output logic                                       pready,
  output logic                                       pslverr,
  // input mux controls, one-hot: ext0, ext1, dac0, dac1; inverting select all zero in unity mode
  output logic      [oac_pkg::NUM_AMPS-1:0][3:0]     invInputSel,
  output logic      [oac_pkg::NUM_AMPS-1:0][3:0]     nonInvInputSel,
  output logic      [oac_pkg::NUM_AMPS-1:0]          invExtPathEn,
  // feedback controls
  output logic      [oac_pkg::NUM_AMPS-1:0]          unityFeedbackEn,
  output logic      [oac_pkg::NUM_AMPS-1:0]          invertFeedbackEn,
  output logic      [oac_pkg::NUM_AMPS-1:0]          funcReserved,
  // power and output routing
  output logic      [oac_pkg::NUM_AMPS-1:0][1:0]     powerSlewMode,
  output logic      [oac_pkg::NUM_AMPS-1:0]          ampPowered,
  output logic      [oac_pkg::NUM_AMPS-1:0]          outHighZ,
  output logic      [oac_pkg::NUM_AMPS-1:0]          extConvRouteEn,
  output logic      [oac_pkg::NUM_AMPS-1:0]          intConvRouteEn,
  // raw switch byte for the analog switch matrix
  output logic      [oac_pkg::REG_W-1:0]             swCtrl
);

  localparam int unsigned IDX_W = oac_pkg::ADDR_W - 2;

  // address decode: {hit, slot}
  function automatic logic [oac_pkg::SLOT_W:0] decode_slot(input logic [oac_pkg::ADDR_W-1:0] addr);
    logic [IDX_W-1:0] idx;
    logic [oac_pkg::SLOT_W:0] res;
    idx = addr[oac_pkg::ADDR_W-1:2];
    res = '0;
    // byte addresses off the word grid never hit
    if (addr[1:0] == 2'h0) begin
      for (int i = 0; i < oac_pkg::NUM_REGS; i++) begin
        if (idx == {{(IDX_W-8){1'b0}}, oac_pkg::REG_INDEX[i]}) begin
          res = {1'b1, oac_pkg::SLOT_W'(i)};
        end
      end
    end
    decode_slot = res;
  endfunction : decode_slot

  oac_pkg::oac_state_t                          state_q;
  oac_pkg::oac_state_t                          state_d;
  logic [oac_pkg::SLOT_W:0]                     decoded;
  logic                                         addrHit;
  logic [oac_pkg::SLOT_W-1:0]                   addrSlot;
  logic                                         accessStart;
  logic                                         wrStrobe;
  logic [oac_pkg::DATA_W-1:0]                   readVal;
  logic [oac_pkg::NUM_REGS-1:0][oac_pkg::REG_W-1:0] regValue;

  assign decoded     = decode_slot(paddr);
  assign addrHit     = decoded[oac_pkg::SLOT_W];
  assign addrSlot    = decoded[oac_pkg::SLOT_W-1:0];
  assign accessStart = (state_q == oac_pkg::OAC_ST_IDLE) && psel && penable;

  // write lands on the edge where pready is seen high; lane 0 carries the byte
  assign wrStrobe = (state_q == oac_pkg::OAC_ST_RESP) && psel && penable && pwrite && addrHit && pstrb[0];

  always_comb begin
    readVal = '0;
    if (addrHit) begin
      readVal = {{(oac_pkg::DATA_W-oac_pkg::REG_W){1'b0}}, regValue[addrSlot]};
    end
  end

  // one wait state: answer in the cycle after the access phase opens
  always_comb begin
    state_d = state_q;
    case (state_q)
      oac_pkg::OAC_ST_IDLE: begin
        if (psel && penable) begin
          state_d = oac_pkg::OAC_ST_RESP;
        end
      end
      oac_pkg::OAC_ST_RESP: begin
        state_d = oac_pkg::OAC_ST_IDLE;
      end
      default: begin
        state_d = oac_pkg::OAC_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      state_q <= oac_pkg::OAC_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pready <= 1'b0;
    end else begin
      pready <= (state_d == oac_pkg::OAC_ST_RESP);
    end
  end

  // read data and error are captured before any write of the same transfer
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else if (accessStart) begin
      prdata  <= pwrite ? '0 : readVal;
      pslverr <= !addrHit;
    end else if (state_q == oac_pkg::OAC_ST_RESP) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end
  end

  // register storage; all 8 bits stored so software reads back the low byte it wrote
  for (genvar r = 0; r < oac_pkg::NUM_REGS; r++) begin : g_reg
    oac_ctrl_reg #(
      .WIDTH     (oac_pkg::REG_W),
      .RESET_VAL (oac_pkg::REG_RESET)
    ) u_reg (
      .core_clk (core_clk),
      .reset_n  (reset_n),
      .wrEn     (wrStrobe && (addrSlot == oac_pkg::SLOT_W'(r))),
      .wrData   (pwdata[oac_pkg::REG_W-1:0]),
      .value    (regValue[r])
    );
  end

  // switch byte is stored only; its forcing effects live in the analog matrix
  assign swCtrl = regValue[oac_pkg::SLOT_SWITCH];

  // per-amplifier decode, outputs registered inside
  for (genvar a = 0; a < oac_pkg::NUM_AMPS; a++) begin : g_amp
    oac_amp_route u_route (
      .core_clk         (core_clk),
      .reset_n          (reset_n),
      .ctrlA            (regValue[2*a]),
      .ctrlB            (regValue[2*a+1]),
      .invInputSel      (invInputSel[a]),
      .nonInvInputSel   (nonInvInputSel[a]),
      .invExtPathEn     (invExtPathEn[a]),
      .unityFeedbackEn  (unityFeedbackEn[a]),
      .invertFeedbackEn (invertFeedbackEn[a]),
      .powerSlewMode    (powerSlewMode[a]),
      .ampPowered       (ampPowered[a]),
      .outHighZ         (outHighZ[a]),
      .extConvRouteEn   (extConvRouteEn[a]),
      .intConvRouteEn   (intConvRouteEn[a]),
      .funcReserved     (funcReserved[a])
    );
  end

endmodule : oac_config_regs

// ===== hw/oac_pkg.sv
// constants, field layout and encodings of the amplifier configuration register bank
// assumes one 40 MHz clock domain and a 32-bit APB master on the register side
//
// Function
// - two byte control registers per amplifier, three amplifiers, consecutive even/odd addresses
// - control A bits 7:6 drive inverting mux: ext0, ext1, first DAC, second DAC
// - control A bits 5:4 drive non-inverting mux: ext0, ext1, first DAC, second DAC
// - control A bits 3:2 set power/slew: off with high-Z output, slow, medium, fast
// - control A bit 1 routes output to external converter only while function nonzero
// - control A bit 0 routes output to internal converter only while power nonzero
// - unity-gain mode feeds output to inverting input, external inverting path cut
// - general-purpose mode uses both selects and provides no internal feedback
package oac_pkg;

  // bus and bank geometry
  localparam int unsigned ADDR_W      = 12;
  localparam int unsigned DATA_W      = 32;
  localparam int unsigned REG_W       = 8;
  localparam int unsigned NUM_AMPS    = 3;
  localparam int unsigned NUM_REGS    = 7;
  localparam int unsigned SLOT_W      = 3;
  localparam int unsigned SLOT_SWITCH = 6;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_AMP0_A  = 8'hC0;
  localparam logic [7:0] IDX_AMP0_B  = 8'hC1;
  localparam logic [7:0] IDX_AMP1_A  = 8'hC2;
  localparam logic [7:0] IDX_AMP1_B  = 8'hC3;
  localparam logic [7:0] IDX_AMP2_A  = 8'hC4;
  localparam logic [7:0] IDX_AMP2_B  = 8'hC5;
  localparam logic [7:0] IDX_SWITCH  = 8'hCF;

  // slot order: amp k control A at 2k, control B at 2k+1, switch last
  localparam logic [7:0] REG_INDEX [NUM_REGS] = '{IDX_AMP0_A, IDX_AMP0_B, IDX_AMP1_A, IDX_AMP1_B,
                                                  IDX_AMP2_A, IDX_AMP2_B, IDX_SWITCH};

  localparam logic [7:0] REG_RESET = 8'h00;

  // control A fields
  localparam int unsigned INV_SEL_HI    = 7;
  localparam int unsigned INV_SEL_LO    = 6;
  localparam int unsigned NONINV_SEL_HI = 5;
  localparam int unsigned NONINV_SEL_LO = 4;
  localparam int unsigned PWR_HI        = 3;
  localparam int unsigned PWR_LO        = 2;
  localparam int unsigned EXT_ROUTE_BIT = 1;
  localparam int unsigned INT_ROUTE_BIT = 0;

  // control B fields
  localparam int unsigned FBTAP_HI  = 7;
  localparam int unsigned FBTAP_LO  = 5;
  localparam int unsigned FUNC_HI   = 4;
  localparam int unsigned FUNC_LO   = 2;
  localparam int unsigned RANGE_BIT = 0;

  // mux select codes
  localparam logic [1:0] SEL_EXT0 = 2'h0;
  localparam logic [1:0] SEL_EXT1 = 2'h1;
  localparam logic [1:0] SEL_DAC0 = 2'h2;
  localparam logic [1:0] SEL_DAC1 = 2'h3;

  // power/slew codes
  localparam logic [1:0] PWR_OFF  = 2'h0;
  localparam logic [1:0] PWR_SLOW = 2'h1;
  localparam logic [1:0] PWR_MED  = 2'h2;
  localparam logic [1:0] PWR_FAST = 2'h3;

  // function codes
  localparam logic [2:0] FUNC_GENERAL = 3'h0;
  localparam logic [2:0] FUNC_UNITY   = 3'h1;
  localparam logic [2:0] FUNC_INVERT  = 3'h6;

  // one-hot mux positions
  localparam logic [3:0] ONEHOT_EXT0 = 4'h1;
  localparam logic [3:0] ONEHOT_EXT1 = 4'h2;
  localparam logic [3:0] ONEHOT_DAC0 = 4'h4;
  localparam logic [3:0] ONEHOT_DAC1 = 4'h8;
  localparam logic [3:0] ONEHOT_NONE = 4'h0;

  // bus slave states
  typedef enum logic [1:0] {
    OAC_ST_IDLE = 2'b01,
    OAC_ST_RESP = 2'b10
  } oac_state_t;

endpackage : oac_pkg

// ===== hw/oac_ctrl_reg.sv
// one byte-wide read/write control register with synchronous clear
// assumes the write strobe is a single-cycle pulse from the bus slave
`timescale 1ns/1ps
module oac_ctrl_reg #(
  parameter int unsigned         WIDTH     = 8,
  parameter logic [WIDTH-1:0]    RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             core_clk,
  input  wire logic             reset_n,
  // write side
  input  wire logic             wrEn,
  input  wire logic [WIDTH-1:0] wrData,
  // stored value
  output logic      [WIDTH-1:0] value
);

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      value <= RESET_VAL;
    end else if (wrEn) begin
      value <= wrData;
    end
  end

endmodule : oac_ctrl_reg

// ===== hw/oac_amp_route.sv
// decodes one amplifier's two control bytes into registered analog switch controls
// assumes control bytes come from flops in the same clock domain
`timescale 1ns/1ps
module oac_amp_route (
  // clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // control bytes
  input  wire logic [7:0] ctrlA,
  input  wire logic [7:0] ctrlB,
  // input muxes
  output logic      [3:0] invInputSel,
  output logic      [3:0] nonInvInputSel,
  output logic            invExtPathEn,
  // feedback
  output logic            unityFeedbackEn,
  output logic            invertFeedbackEn,
  // power and output
  output logic      [1:0] powerSlewMode,
  output logic            ampPowered,
  output logic            outHighZ,
  output logic            extConvRouteEn,
  output logic            intConvRouteEn,
  output logic            funcReserved
);

  function automatic logic [3:0] sel_one_hot(input logic [1:0] sel);
    case (sel)
      oac_pkg::SEL_EXT0: sel_one_hot = oac_pkg::ONEHOT_EXT0;
      oac_pkg::SEL_EXT1: sel_one_hot = oac_pkg::ONEHOT_EXT1;
      oac_pkg::SEL_DAC0: sel_one_hot = oac_pkg::ONEHOT_DAC0;
      oac_pkg::SEL_DAC1: sel_one_hot = oac_pkg::ONEHOT_DAC1;
      default:           sel_one_hot = oac_pkg::ONEHOT_NONE;
    endcase
  endfunction : sel_one_hot

  logic [1:0] invSel;
  logic [1:0] nonInvSel;
  logic [1:0] pwr;
  logic [2:0] func;
  logic       isUnity;
  logic       isInvert;
  logic       isGeneral;

  assign invSel    = ctrlA[oac_pkg::INV_SEL_HI:oac_pkg::INV_SEL_LO];
  assign nonInvSel = ctrlA[oac_pkg::NONINV_SEL_HI:oac_pkg::NONINV_SEL_LO];
  assign pwr       = ctrlA[oac_pkg::PWR_HI:oac_pkg::PWR_LO];
  assign func      = ctrlB[oac_pkg::FUNC_HI:oac_pkg::FUNC_LO];
  assign isUnity   = (func == oac_pkg::FUNC_UNITY);
  assign isInvert  = (func == oac_pkg::FUNC_INVERT);
  assign isGeneral = (func == oac_pkg::FUNC_GENERAL);

  // input muxes; unity mode ignores the inverting select
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      invInputSel    <= oac_pkg::ONEHOT_EXT0;
      nonInvInputSel <= oac_pkg::ONEHOT_EXT0;
      invExtPathEn   <= 1'b1;
    end else begin
      invInputSel    <= isUnity ? oac_pkg::ONEHOT_NONE : sel_one_hot(invSel);
      nonInvInputSel <= sel_one_hot(nonInvSel);
      invExtPathEn   <= !isUnity;
    end
  end

  // feedback; reserved codes get no internal feedback, like general purpose
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      unityFeedbackEn  <= 1'b0;
      invertFeedbackEn <= 1'b0;
      funcReserved     <= 1'b0;
    end else begin
      unityFeedbackEn  <= isUnity;
      invertFeedbackEn <= isInvert;
      funcReserved     <= !(isUnity || isInvert || isGeneral);
    end
  end

  // power and converter routing
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      powerSlewMode  <= oac_pkg::PWR_OFF;
      ampPowered     <= 1'b0;
      outHighZ       <= 1'b1;
      extConvRouteEn <= 1'b0;
      intConvRouteEn <= 1'b0;
    end else begin
      powerSlewMode  <= pwr;
      ampPowered     <= (pwr != oac_pkg::PWR_OFF);
      outHighZ       <= (pwr == oac_pkg::PWR_OFF);
      extConvRouteEn <= ctrlA[oac_pkg::EXT_ROUTE_BIT] && (func != oac_pkg::FUNC_GENERAL);
      intConvRouteEn <= ctrlA[oac_pkg::INT_ROUTE_BIT] && (pwr != oac_pkg::PWR_OFF);
    end
  end

endmodule : oac_amp_route

// ===== tb/oac_config_regs_monitor.sv
// assertions on the apb slave and decoded amplifier controls
// assumes it is bound to oac_config_regs and sees only its ports
`timescale 1ns/1ps
module oac_config_regs_monitor (
  // clock and reset
  input wire logic                              core_clk,
  input wire logic                              reset_n,
  // apb
  input wire logic                              psel,
  input wire logic                              penable,
  input wire logic                              pwrite,
  input wire logic [oac_pkg::ADDR_W-1:0]        paddr,
  input wire logic [oac_pkg::DATA_W-1:0]        pwdata,
  input wire logic [3:0]                        pstrb,
  input wire logic                              pready,
  input wire logic                              pslverr,
  // amplifier controls
  input wire logic [oac_pkg::NUM_AMPS-1:0][3:0] invInputSel,
  input wire logic [oac_pkg::NUM_AMPS-1:0]      invExtPathEn,
  input wire logic [oac_pkg::NUM_AMPS-1:0]      unityFeedbackEn,
  input wire logic [oac_pkg::NUM_AMPS-1:0][1:0] powerSlewMode,
  input wire logic [oac_pkg::NUM_AMPS-1:0]      ampPowered,
  input wire logic [oac_pkg::NUM_AMPS-1:0]      outHighZ,
  input wire logic [oac_pkg::NUM_AMPS-1:0]      intConvRouteEn,
  input wire logic [oac_pkg::REG_W-1:0]         swCtrl
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  sequence s_access; psel && penable && !pready; endsequence
  sequence s_wr_done; psel && penable && pready && pwrite && pstrb[0]; endsequence
  sequence s_wr_amp0a; s_wr_done ##0 paddr == 12'h300; endsequence
  sequence s_wr_sw; s_wr_done ##0 paddr == 12'h33C; endsequence
  property p_one_wait; s_access |=> pready; endproperty
  a_one_wait: assert property (p_one_wait) else $error("pready late");
  property p_ready_pulse; pready |=> !pready; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");
  property p_misaligned; pready && paddr[1:0] != 2'h0 |-> pslverr; endproperty
  a_misaligned: assert property (p_misaligned) else $error("misaligned accepted");
  property p_sw_write; s_wr_sw |=> swCtrl == $past(pwdata[7:0]); endproperty
  a_sw_write: assert property (p_sw_write) else $error("switch byte not written");
  // a write that did not complete must leave the byte alone
  property p_sw_hold; !(psel && penable && pready && pwrite) |=> $stable(swCtrl); endproperty
  a_sw_hold: assert property (p_sw_hold) else $error("switch byte changed");
  property p_pwr_write; s_wr_amp0a |-> ##2 powerSlewMode[0] == $past(pwdata[3:2], 2); endproperty
  a_pwr_write: assert property (p_pwr_write) else $error("power mode not applied");
  for (genvar k = 0; k < oac_pkg::NUM_AMPS; k++) begin : g_amp
    property p_highz; outHighZ[k] == (powerSlewMode[k] == 2'h0) && ampPowered[k] == !outHighZ[k]; endproperty
    a_highz: assert property (p_highz) else $error("high-z mismatch");
    property p_int_route; intConvRouteEn[k] |-> ampPowered[k]; endproperty
    a_int_route: assert property (p_int_route) else $error("route while off");
    property p_unity; unityFeedbackEn[k] |-> invInputSel[k] == 4'h0 && !invExtPathEn[k]; endproperty
    a_unity: assert property (p_unity) else $error("unity path open");
    property p_inv_sel; !unityFeedbackEn[k] |-> $onehot(invInputSel[k]) && invExtPathEn[k]; endproperty
    a_inv_sel: assert property (p_inv_sel) else $error("inverting select bad");
  end
endmodule : oac_config_regs_monitor

bind oac_config_regs oac_config_regs_monitor u_mon (
  .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .pslverr(pslverr),
  .invInputSel(invInputSel), .invExtPathEn(invExtPathEn), .unityFeedbackEn(unityFeedbackEn),
  .powerSlewMode(powerSlewMode), .ampPowered(ampPowered), .outHighZ(outHighZ),
  .intConvRouteEn(intConvRouteEn), .swCtrl(swCtrl));

// ===== tb/oac_config_regs_bench.sv
// self-checking bench for the amplifier configuration register bank
// assumes an apb slave on core_clk; the bench waits for pready, not a fixed count
`timescale 1ns/1ps
module oac_config_regs_bench;
  logic                              core_clk = 1'b0;
  logic                              reset_n  = 1'b0;
  logic                              psel     = 1'b0;
  logic                              penable  = 1'b0;
  logic                              pwrite   = 1'b0;
  logic [oac_pkg::ADDR_W-1:0]        paddr    = '0;
  logic [oac_pkg::DATA_W-1:0]        pwdata   = '0;
  logic [3:0]                        pstrb    = 4'hF;
  logic [oac_pkg::DATA_W-1:0]        prdata, rd;
  logic                              pready, pslverr, err;
  logic [oac_pkg::NUM_AMPS-1:0][3:0] invInputSel, nonInvInputSel;
  logic [oac_pkg::NUM_AMPS-1:0][1:0] powerSlewMode;
  logic [oac_pkg::NUM_AMPS-1:0]      invExtPathEn, unityFeedbackEn, invertFeedbackEn, funcReserved;
  logic [oac_pkg::NUM_AMPS-1:0]      ampPowered, outHighZ, extConvRouteEn, intConvRouteEn;
  logic [oac_pkg::REG_W-1:0]         swCtrl;
  logic [1:0]                        cc;
  int                                fail_count = 0;
  int                                n_compared = 0;

  always #12.5 core_clk = ~core_clk;

  oac_config_regs DUT (
    .core_clk(core_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .invInputSel(invInputSel), .nonInvInputSel(nonInvInputSel),
    .invExtPathEn(invExtPathEn), .unityFeedbackEn(unityFeedbackEn), .invertFeedbackEn(invertFeedbackEn),
    .funcReserved(funcReserved), .powerSlewMode(powerSlewMode), .ampPowered(ampPowered),
    .outHighZ(outHighZ), .extConvRouteEn(extConvRouteEn), .intConvRouteEn(intConvRouteEn),
    .swCtrl(swCtrl));

  function automatic logic [11:0] addrOf(input int i);
    return {2'h0, oac_pkg::REG_INDEX[i], 2'h0};
  endfunction : addrOf

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // one apb transfer; request held until pready is sampled high
  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    @(posedge core_clk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    pstrb <= s;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // decoded controls lag the register by one clock
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #1;
  endtask : settle

  task automatic final_report();
    if (fail_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : final_report

  initial begin
    #200000;
    fail_count++;
    final_report();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    #1;
    check(invInputSel, {3{4'h1}});
    check(outHighZ, 3'h7);
    for (int i = 0; i < oac_pkg::NUM_REGS; i++) begin
      xfer(addrOf(i), 1'b0, 32'h0, 4'hF);
      check(rd, 32'h0);
    end
    for (int i = 0; i < oac_pkg::NUM_REGS; i++) xfer(addrOf(i), 1'b1, 32'hFFFFFF5A ^ i, 4'h1);
    for (int i = 0; i < oac_pkg::NUM_REGS; i++) begin
      xfer(addrOf(i), 1'b0, 32'h0, 4'hF);
      check(rd, 32'h5A ^ i);
    end
    check(swCtrl, 8'h5C);
    // amp0/1 function 110 inverting, amp2 111 reserved; routes and power from the written A bytes
    check({invertFeedbackEn, funcReserved, extConvRouteEn, ampPowered}, 12'h72F);
    xfer(12'h318, 1'b0, 32'h0, 4'hF);
    check({rd[30:0], err}, 32'h1);
    xfer(12'h301, 1'b1, 32'hFF, 4'hF);
    check(err, 1'b1);
    xfer(12'h300, 1'b1, 32'h00, 4'h0);
    xfer(12'h300, 1'b0, 32'h0, 4'hF);
    check(rd, 32'h5A);
    xfer(12'h304, 1'b1, 32'h00, 4'hF);
    for (int c = 0; c < 4; c++) begin
      cc = c[1:0];
      xfer(12'h300, 1'b1, {24'h0, cc, cc, cc, 2'b11}, 4'hF);
      settle();
      check(invInputSel[0], 4'h1 << cc);
      check(nonInvInputSel[0], 4'h1 << cc);
      check({powerSlewMode[0], outHighZ[0]}, {cc, cc == 2'h0});
      check(ampPowered[0], cc != 2'h0);
      check(intConvRouteEn[0], cc != 2'h0);
      check(extConvRouteEn[0], 1'b0);
      check({unityFeedbackEn[0], invExtPathEn[0]}, 2'b01);
    end
    xfer(12'h300, 1'b1, 32'hE7, 4'hF);
    for (int f = 0; f < 8; f++) begin
      xfer(12'h304, 1'b1, {27'h0, f[2:0], 2'b00}, 4'hF);
      settle();
      check(extConvRouteEn[0], f != 0);
      check({unityFeedbackEn[0], invExtPathEn[0]}, {f == 1, f != 1});
      check(invInputSel[0], (f == 1) ? 4'h0 : 4'h8);
      check(nonInvInputSel[0], 4'h4);
      check({invertFeedbackEn[0], funcReserved[0]}, {f == 6, !(f == 0 || f == 1 || f == 6)});
    end
    @(posedge core_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge core_clk);
    reset_n <= 1'b1;
    xfer(12'h300, 1'b0, 32'h0, 4'hF);
    check(rd, 32'h0);
    check({swCtrl, outHighZ}, 11'h7);
    final_report();
  end
endmodule : oac_config_regs_bench
